// ==== verilog/mtc_consts.svh ====
// register offsets, field positions and reset values of the timer count block
// assumes inclusion by bare name from the package and design files
`ifndef MTC_CONSTS_SVH
`define MTC_CONSTS_SVH

// ----------------------------------------------------------------------
// register byte offsets
// ----------------------------------------------------------------------
`define MTC_OFF_FIRST_COUNT   8'h00
`define MTC_OFF_CAPTURE_A     8'h04
`define MTC_OFF_CAPTURE_B     8'h08
`define MTC_OFF_SECOND_COUNT  8'h0C
`define MTC_OFF_DIVIDER       8'h10
`define MTC_OFF_CONTROL       8'h24

// ----------------------------------------------------------------------
// control register fields
// ----------------------------------------------------------------------
`define MTC_CTL_ENABLE_BIT    0
`define MTC_CTL_TRIG_EN_BIT   1
`define MTC_CTL_START_BIT     2
`define MTC_CTL_TRAIN_BIT     3
`define MTC_CTL_MODE_LSB      4
`define MTC_CTL_CSEL1_LSB     6
`define MTC_CTL_CSEL2_LSB     9
`define MTC_CTL_USED_MASK     32'h00000FFB

// ----------------------------------------------------------------------
// widths and reset values
// ----------------------------------------------------------------------
`define MTC_COUNT_W           16
`define MTC_DIV_W             8
`define MTC_DIVIDER_RESET     8'h00
`define MTC_CLKSEL_RESET      3'h0
`define MTC_MODE_RESET        2'h0

`endif

// ==== verilog/mtc_pkg.sv ====
// types used by the timer count block, not by its prescaler
// assumes mtc_consts.svh is on the include path
`include "mtc_consts.svh"
`default_nettype none

package mtc_pkg;

  // operating mode select codes
  typedef enum logic [1:0]
  {
    MTC_MODE_PWM_COUNTER = 2'h0,
    MTC_MODE_DUAL_CAPT   = 2'h1,
    MTC_MODE_DUAL_INDEP  = 2'h2,
    MTC_MODE_CAPT_TIMER  = 2'h3
  } mtc_mode_t;

  // counter clock source codes
  typedef enum logic [2:0]
  {
    MTC_CLK_NONE      = 3'h0,
    MTC_CLK_PRESCALED = 3'h1,
    MTC_CLK_EXT_EVENT = 3'h2,
    MTC_CLK_PULSE_ACC = 3'h3
  } mtc_clksel_t;

endpackage

`default_nettype wire

// ==== verilog/mtc_prescaler.sv ====
// prescaler: divides the system clock by the active setting plus one
// assumes a synchronous active-low reset on the same clock as the parent
`include "mtc_consts.svh"
`default_nettype none

module mtc_prescaler
(
  // clock and reset
  input  wire logic                   i_clk,
  input  wire logic                   i_resetn,
  // control
  input  wire logic                   i_run,
  input  wire logic [`MTC_DIV_W-1:0]  i_setting,
  input  wire logic                   i_pulse_train,
  input  wire logic                   i_load_now,
  // tick out
  output var  logic                   o_tick
);

  logic [`MTC_DIV_W-1:0] active_reg;
  logic [`MTC_DIV_W-1:0] count_reg;
  logic                  underflow;

  assign underflow = i_run && (count_reg == '0);

  // ----------------------------------------------------------------------
  // active setting and down counter
  // ----------------------------------------------------------------------
  always_ff @(posedge i_clk)
  begin
    if (!i_resetn)
    begin
      active_reg <= `MTC_DIVIDER_RESET;
      count_reg  <= `MTC_DIVIDER_RESET;
    end
    else if (i_load_now)
    begin
      active_reg <= i_setting;
      count_reg  <= i_setting;
    end
    else if (!i_run)
    begin
      count_reg <= active_reg;
    end
    else if (underflow)
    begin
      if (!i_pulse_train)
      begin
        active_reg <= i_setting;
        count_reg  <= i_setting;
      end
      else
      begin
        count_reg <= active_reg;
      end
    end
    else
    begin
      count_reg <= count_reg - 8'h01;
    end
  end

  always_ff @(posedge i_clk)
  begin
    if (!i_resetn)
      o_tick <= 1'b0;
    else
      o_tick <= underflow && !i_load_now;
  end

  // ----------------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------------
  property p_reload_after_underflow;
    @(posedge i_clk) disable iff (!i_resetn)
      (underflow && !i_load_now && i_pulse_train) |=> (count_reg == $past(active_reg));
  endproperty
  a_reload_after_underflow: assert property (p_reload_after_underflow)
    else $error("prescaler did not reload active setting");

  property p_hold_until_underflow;
    @(posedge i_clk) disable iff (!i_resetn)
      (i_run && !underflow && !i_load_now) |=> $stable(active_reg);
  endproperty
  a_hold_until_underflow: assert property (p_hold_until_underflow)
    else $error("prescaler setting applied before underflow");

  property p_train_load;
    @(posedge i_clk) disable iff (!i_resetn)
      i_load_now |=> (active_reg == $past(i_setting)) && !o_tick;
  endproperty
  a_train_load: assert property (p_train_load)
    else $error("pulse train start did not apply setting");

  property p_divide_ratio;
    @(posedge i_clk) disable iff (!i_resetn)
      (underflow && !i_load_now) ##1
      (i_run && !i_load_now && active_reg == 8'h01)[*2]
      |-> $past(o_tick) && !o_tick ##1 o_tick;
  endproperty
  a_divide_ratio: assert property (p_divide_ratio)
    else $error("divide by two ratio wrong");

endmodule // mtc_prescaler

`default_nettype wire

// ==== verilog/mtc_count_regs.sv ====
// multifunction timer counting core: two counters, two capture/reload
// registers and the clock prescaler, reached over an APB slave port
// assumes one system clock, synchronous active-low reset, 32-bit APB master
//
// Behaviour
// - first counter 16 bits, not reset
// - first counter read returns live value
// - first counter written only while enabled
// - second counter 16 bits, not reset
// - second counter read returns live value
// - second counter written only while enabled
// - capture A 16 bits, not reset, readable
// - capture A written only while enabled
// - capture B 16 bits, not reset, readable
// - capture B written only while enabled
// - prescaler setting writable at any time
// - new setting applied at prescaler underflow
// - pulse train applies setting on start/trigger
// - timer clock is system clock over setting+1
// - prescaled clock drives counter when select 001b
// - pulse train is variant of mode 00b
//
// Register access over APB is this design's own decision.
`include "mtc_consts.svh"
`default_nettype none

module mtc_count_regs
(
  // clock and reset
  input  wire logic        i_clk,
  input  wire logic        i_resetn,
  // apb slave
  input  wire logic        i_psel,
  input  wire logic        i_penable,
  input  wire logic        i_pwrite,
  input  wire logic [7:0]  i_paddr,
  input  wire logic [31:0] i_pwdata,
  output var  logic        o_pready,
  output var  logic [31:0] o_prdata,
  output var  logic        o_pslverr,
  // timer pin
  input  wire logic        i_timer_input_b,
  // prescaled timer clock tick
  output var  logic        o_timer_tick
);

  // ----------------------------------------------------------------------
  // decode helpers
  // ----------------------------------------------------------------------
  function automatic logic reg_hit(input logic [7:0] addr, input logic [7:0] off);
    return addr == off;
  endfunction

  function automatic logic addr_mapped(input logic [7:0] addr);
    return reg_hit(addr, `MTC_OFF_FIRST_COUNT) || reg_hit(addr, `MTC_OFF_CAPTURE_A)
        || reg_hit(addr, `MTC_OFF_CAPTURE_B) || reg_hit(addr, `MTC_OFF_SECOND_COUNT)
        || reg_hit(addr, `MTC_OFF_DIVIDER) || reg_hit(addr, `MTC_OFF_CONTROL);
  endfunction

  // ----------------------------------------------------------------------
  // state
  // ----------------------------------------------------------------------
  logic [`MTC_COUNT_W-1:0] first_count_value_reg;
  logic [`MTC_COUNT_W-1:0] second_count_value_reg;
  logic [`MTC_COUNT_W-1:0] capture_reload_a_value_reg;
  logic [`MTC_COUNT_W-1:0] capture_reload_b_value_reg;
  logic [`MTC_DIV_W-1:0]   clock_divider_setting_reg;
  logic                    timer_enable_bit_reg;
  logic                    pulse_train_trigger_enable_reg;
  logic                    pulse_train_start_bit_reg;
  logic                    pulse_train_select_reg;
  mtc_pkg::mtc_mode_t      operating_mode_select_reg;
  mtc_pkg::mtc_clksel_t    first_counter_clock_select_reg;
  mtc_pkg::mtc_clksel_t    second_counter_clock_select_reg;
  logic                    in_b_meta_reg;
  logic                    in_b_sync2_reg;
  logic                    in_b_sync3_reg;
  logic                    in_b_stable_reg;
  logic [31:0]             read_next;

  logic access_phase;
  logic write_fire;
  logic in_b_event;
  logic pulse_train;
  logic load_now;
  logic prescale_tick;
  logic first_write;
  logic second_write;
  logic cap_a_write;
  logic cap_b_write;
  logic first_step;
  logic second_step;

  // ----------------------------------------------------------------------
  // apb handshake: one wait state, answer at second access cycle
  // ----------------------------------------------------------------------
  assign access_phase = i_psel && i_penable;
  assign write_fire   = access_phase && o_pready && i_pwrite;

  always_ff @(posedge i_clk)
  begin
    if (!i_resetn)
      o_pready <= 1'b0;
    else
      o_pready <= access_phase && !o_pready;
  end

  always_ff @(posedge i_clk)
  begin
    if (!i_resetn)
      o_pslverr <= 1'b0;
    else
      o_pslverr <= access_phase && !o_pready && !addr_mapped(i_paddr);
  end

  // ----------------------------------------------------------------------
  // read data: live values, reserved bits zero
  // ----------------------------------------------------------------------
  always_comb
  begin
    read_next = 32'h00000000;
    case (i_paddr)
      `MTC_OFF_FIRST_COUNT:  read_next[15:0] = first_count_value_reg;
      `MTC_OFF_CAPTURE_A:    read_next[15:0] = capture_reload_a_value_reg;
      `MTC_OFF_CAPTURE_B:    read_next[15:0] = capture_reload_b_value_reg;
      `MTC_OFF_SECOND_COUNT: read_next[15:0] = second_count_value_reg;
      `MTC_OFF_DIVIDER:      read_next[7:0]  = clock_divider_setting_reg;
      `MTC_OFF_CONTROL:
      begin
        read_next[`MTC_CTL_ENABLE_BIT]  = timer_enable_bit_reg;
        read_next[`MTC_CTL_TRIG_EN_BIT] = pulse_train_trigger_enable_reg;
        read_next[`MTC_CTL_TRAIN_BIT]   = pulse_train_select_reg;
        read_next[`MTC_CTL_MODE_LSB +: 2]  = operating_mode_select_reg;
        read_next[`MTC_CTL_CSEL1_LSB +: 3] = first_counter_clock_select_reg;
        read_next[`MTC_CTL_CSEL2_LSB +: 3] = second_counter_clock_select_reg;
      end
      default:               read_next = 32'h00000000;
    endcase
  end

  always_ff @(posedge i_clk)
  begin
    if (!i_resetn)
      o_prdata <= 32'h00000000;
    else if (access_phase && !o_pready && !i_pwrite)
      o_prdata <= read_next;
  end

  // ----------------------------------------------------------------------
  // control register
  // ----------------------------------------------------------------------
  always_ff @(posedge i_clk)
  begin
    if (!i_resetn)
    begin
      timer_enable_bit_reg            <= 1'b0;
      pulse_train_trigger_enable_reg  <= 1'b0;
      pulse_train_select_reg          <= 1'b0;
      operating_mode_select_reg       <= mtc_pkg::mtc_mode_t'(`MTC_MODE_RESET);
      first_counter_clock_select_reg  <= mtc_pkg::mtc_clksel_t'(`MTC_CLKSEL_RESET);
      second_counter_clock_select_reg <= mtc_pkg::mtc_clksel_t'(`MTC_CLKSEL_RESET);
    end
    else if (write_fire && reg_hit(i_paddr, `MTC_OFF_CONTROL))
    begin
      timer_enable_bit_reg            <= i_pwdata[`MTC_CTL_ENABLE_BIT];
      pulse_train_trigger_enable_reg  <= i_pwdata[`MTC_CTL_TRIG_EN_BIT];
      pulse_train_select_reg          <= i_pwdata[`MTC_CTL_TRAIN_BIT];
      operating_mode_select_reg       <= mtc_pkg::mtc_mode_t'(i_pwdata[`MTC_CTL_MODE_LSB +: 2]);
      first_counter_clock_select_reg  <=
        mtc_pkg::mtc_clksel_t'(i_pwdata[`MTC_CTL_CSEL1_LSB +: 3]);
      second_counter_clock_select_reg <=
        mtc_pkg::mtc_clksel_t'(i_pwdata[`MTC_CTL_CSEL2_LSB +: 3]);
    end
  end

  // start bit is a one-cycle strobe, reads back zero
  always_ff @(posedge i_clk)
  begin
    if (!i_resetn)
      pulse_train_start_bit_reg <= 1'b0;
    else
      pulse_train_start_bit_reg <= write_fire && reg_hit(i_paddr, `MTC_OFF_CONTROL)
                                   && i_pwdata[`MTC_CTL_START_BIT];
  end

  // ----------------------------------------------------------------------
  // prescaler setting, writable whatever the enable state
  // ----------------------------------------------------------------------
  always_ff @(posedge i_clk)
  begin
    if (!i_resetn)
      clock_divider_setting_reg <= `MTC_DIVIDER_RESET;
    else if (write_fire && reg_hit(i_paddr, `MTC_OFF_DIVIDER))
      clock_divider_setting_reg <= i_pwdata[7:0];
  end

  // ----------------------------------------------------------------------
  // input b synchroniser and rising edge event
  // ----------------------------------------------------------------------
  always_ff @(posedge i_clk)
  begin
    if (!i_resetn)
    begin
      in_b_meta_reg   <= 1'b0;
      in_b_sync2_reg  <= 1'b0;
      in_b_sync3_reg  <= 1'b0;
      in_b_stable_reg <= 1'b0;
    end
    else
    begin
      in_b_meta_reg  <= i_timer_input_b;
      in_b_sync2_reg <= in_b_meta_reg;
      in_b_sync3_reg <= in_b_sync2_reg;
      if (in_b_sync2_reg == in_b_sync3_reg)
        in_b_stable_reg <= in_b_sync3_reg;
    end
  end

  assign in_b_event = (in_b_sync2_reg == in_b_sync3_reg) && in_b_sync3_reg
                      && !in_b_stable_reg;

  // ----------------------------------------------------------------------
  // prescaler
  // ----------------------------------------------------------------------
  assign pulse_train = pulse_train_select_reg
                       && (operating_mode_select_reg == mtc_pkg::MTC_MODE_PWM_COUNTER);
  assign load_now    = pulse_train && (pulse_train_start_bit_reg
                       || (pulse_train_trigger_enable_reg && in_b_event));

  mtc_prescaler u_prescaler
  (
    .i_clk         (i_clk),
    .i_resetn      (i_resetn),
    .i_run         (timer_enable_bit_reg),
    .i_setting     (clock_divider_setting_reg),
    .i_pulse_train (pulse_train),
    .i_load_now    (load_now),
    .o_tick        (prescale_tick)
  );

  always_ff @(posedge i_clk)
  begin
    if (!i_resetn)
      o_timer_tick <= 1'b0;
    else
      o_timer_tick <= prescale_tick;
  end

  // ----------------------------------------------------------------------
  // counters and capture/reload registers, never reset
  // ----------------------------------------------------------------------
  assign first_write  = write_fire && timer_enable_bit_reg
                        && reg_hit(i_paddr, `MTC_OFF_FIRST_COUNT);
  assign second_write = write_fire && timer_enable_bit_reg
                        && reg_hit(i_paddr, `MTC_OFF_SECOND_COUNT);
  assign cap_a_write  = write_fire && timer_enable_bit_reg
                        && reg_hit(i_paddr, `MTC_OFF_CAPTURE_A);
  assign cap_b_write  = write_fire && timer_enable_bit_reg
                        && reg_hit(i_paddr, `MTC_OFF_CAPTURE_B);
  assign first_step   = prescale_tick
                        && (first_counter_clock_select_reg == mtc_pkg::MTC_CLK_PRESCALED);
  assign second_step  = prescale_tick
                        && (second_counter_clock_select_reg == mtc_pkg::MTC_CLK_PRESCALED);

  always_ff @(posedge i_clk)
  begin
    if (first_write)
      first_count_value_reg <= i_pwdata[15:0];
    else if (first_step)
      first_count_value_reg <= first_count_value_reg - 16'h0001;
  end

  always_ff @(posedge i_clk)
  begin
    if (second_write)
      second_count_value_reg <= i_pwdata[15:0];
    else if (second_step)
      second_count_value_reg <= second_count_value_reg - 16'h0001;
  end

  always_ff @(posedge i_clk)
  begin
    if (cap_a_write)
      capture_reload_a_value_reg <= i_pwdata[15:0];
  end

  always_ff @(posedge i_clk)
  begin
    if (cap_b_write)
      capture_reload_b_value_reg <= i_pwdata[15:0];
  end

  // ----------------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------------
  sequence s_setup_access;
    i_psel && !i_penable ##1 i_psel && i_penable && !o_pready;
  endsequence

  property p_apb_one_wait;
    @(posedge i_clk) disable iff (!i_resetn)
      s_setup_access |=> o_pready;
  endproperty
  a_apb_one_wait: assert property (p_apb_one_wait)
    else $error("apb answer not after one wait state");

  property p_first_write_gate;
    @(posedge i_clk) disable iff (!i_resetn)
      (write_fire && reg_hit(i_paddr, `MTC_OFF_FIRST_COUNT) && !timer_enable_bit_reg)
      |=> first_count_value_reg == $past(first_count_value_reg);
  endproperty
  a_first_write_gate: assert property (p_first_write_gate)
    else $error("first counter changed by write while disabled");

  property p_first_write_take;
    @(posedge i_clk) disable iff (!i_resetn)
      first_write |=> first_count_value_reg == $past(i_pwdata[15:0]);
  endproperty
  a_first_write_take: assert property (p_first_write_take)
    else $error("first counter write lost");

  property p_second_write_gate;
    @(posedge i_clk) disable iff (!i_resetn)
      (write_fire && reg_hit(i_paddr, `MTC_OFF_SECOND_COUNT) && !timer_enable_bit_reg)
      |=> second_count_value_reg == $past(second_count_value_reg);
  endproperty
  a_second_write_gate: assert property (p_second_write_gate)
    else $error("second counter changed by write while disabled");

  property p_cap_a_gate;
    @(posedge i_clk) disable iff (!i_resetn)
      (write_fire && reg_hit(i_paddr, `MTC_OFF_CAPTURE_A))
      |=> capture_reload_a_value_reg == ($past(timer_enable_bit_reg)
          ? $past(i_pwdata[15:0]) : $past(capture_reload_a_value_reg));
  endproperty
  a_cap_a_gate: assert property (p_cap_a_gate)
    else $error("capture a write gating wrong");

  property p_cap_b_gate;
    @(posedge i_clk) disable iff (!i_resetn)
      (write_fire && reg_hit(i_paddr, `MTC_OFF_CAPTURE_B))
      |=> capture_reload_b_value_reg == ($past(timer_enable_bit_reg)
          ? $past(i_pwdata[15:0]) : $past(capture_reload_b_value_reg));
  endproperty
  a_cap_b_gate: assert property (p_cap_b_gate)
    else $error("capture b write gating wrong");

  property p_live_read;
    @(posedge i_clk) disable iff (!i_resetn)
      (s_setup_access and (!i_pwrite && reg_hit(i_paddr, `MTC_OFF_SECOND_COUNT))[*2])
      |=> o_prdata == {16'h0000, $past(second_count_value_reg)};
  endproperty
  a_live_read: assert property (p_live_read)
    else $error("second counter read not live");

  property p_step_on_tick;
    @(posedge i_clk) disable iff (!i_resetn)
      (first_step && !first_write)
      |=> first_count_value_reg == $past(first_count_value_reg) - 16'h0001;
  endproperty
  a_step_on_tick: assert property (p_step_on_tick)
    else $error("first counter missed prescaled tick");

  property p_reserved_zero;
    @(posedge i_clk) disable iff (!i_resetn)
      (access_phase && !o_pready && !i_pwrite && !reg_hit(i_paddr, `MTC_OFF_CONTROL))
      |=> o_prdata[31:16] == 16'h0000;
  endproperty
  a_reserved_zero: assert property (p_reserved_zero)
    else $error("reserved bits read non-zero");

endmodule // mtc_count_regs

`default_nettype wire

// ==== dv/mtc_count_regs_tb_top.sv ====
// testbench for the timer count block: apb register access and prescaler
// assumes the design files are compiled first and mtc_consts.svh is on the include path
`include "mtc_consts.svh"
`default_nettype none

module mtc_count_regs_tb_top;
  timeunit 1ns;
  timeprecision 1ps;

  logic        i_clk = 1'b0;
  logic        i_resetn = 1'b0;
  logic        i_psel = 1'b0;
  logic        i_penable = 1'b0;
  logic        i_pwrite = 1'b0;
  logic [7:0]  i_paddr = 8'h00;
  logic [31:0] i_pwdata = 32'h00000000;
  logic        i_timer_input_b = 1'b0;
  logic        o_pready;
  logic [31:0] o_prdata;
  logic        o_pslverr;
  logic        o_timer_tick;
  int          error_cnt = 0;
  int          n_tests = 0;
  int          cycles = 0;
  int          ticks = 0;
  int          t0;
  int          gap;
  logic [31:0] rd;
  logic        err;
  logic [7:0]  offs [4];
  logic [15:0] vals [4];
  int          sets [4] = '{0, 1, 3, 255};
  logic [31:0] csel2_on;

  always #2 i_clk = ~i_clk;

  mtc_count_regs uut
  (
    .i_clk           (i_clk),
    .i_resetn        (i_resetn),
    .i_psel          (i_psel),
    .i_penable       (i_penable),
    .i_pwrite        (i_pwrite),
    .i_paddr         (i_paddr),
    .i_pwdata        (i_pwdata),
    .o_pready        (o_pready),
    .o_prdata        (o_prdata),
    .o_pslverr       (o_pslverr),
    .i_timer_input_b (i_timer_input_b),
    .o_timer_tick    (o_timer_tick)
  );

  // ----------------------------------------------------------------------
  // tick counter and hang guard
  // ----------------------------------------------------------------------
  always @(posedge i_clk)
  begin
    cycles <= cycles + 1;
    ticks  <= ticks + ((o_timer_tick === 1'b1) ? 1 : 0);
    if (cycles == 20000)
    begin
      error_cnt++;
      tally_and_finish();
    end
  end

  // ----------------------------------------------------------------------
  // tasks
  // ----------------------------------------------------------------------
  task automatic tally_and_finish();
    $display("checks %0d mismatches %0d", n_tests, error_cnt);
    if (error_cnt == 0 && n_tests > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask

  task automatic check(input string what, input logic [31:0] exp, input logic [31:0] got);
    n_tests++;
    if (got !== exp)
    begin
      error_cnt++;
      $display("mismatch %s expected %h seen %h", what, exp, got);
    end
  endtask

  // one apb transfer, entered just after a rising edge
  // ends with one idle edge so a following call never reassigns psel in one step
  task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
    i_psel   <= 1'b1;
    i_pwrite <= wr;
    i_paddr  <= a;
    i_pwdata <= d;
    @(posedge i_clk);
    i_penable <= 1'b1;
    do
    begin
      @(posedge i_clk);
    end while (o_pready !== 1'b1);
    rd  = o_prdata;
    err = o_pslverr;
    i_psel    <= 1'b0;
    i_penable <= 1'b0;
    @(posedge i_clk);
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    apb(1'b1, a, d);
  endtask

  task automatic rdchk(input string what, input logic [7:0] a, input logic [31:0] exp);
    apb(1'b0, a, 32'h00000000);
    check(what, exp, rd);
  endtask

  // cycles until o_timer_tick is next seen high
  task automatic wait_tick(output int c);
    c = 0;
    do
    begin
      @(posedge i_clk);
      c++;
    end while (o_timer_tick !== 1'b1 && c < 600);
  endtask

  function automatic logic [31:0] ctl(input logic en, input logic tr, input logic st,
                                      input logic pt, input logic [2:0] c1);
    ctl = 32'h00000000;
    ctl[`MTC_CTL_ENABLE_BIT]  = en;
    ctl[`MTC_CTL_TRIG_EN_BIT] = tr;
    ctl[`MTC_CTL_START_BIT]   = st;
    ctl[`MTC_CTL_TRAIN_BIT]   = pt;
    ctl[`MTC_CTL_CSEL1_LSB +: 3] = c1;
  endfunction

  // ----------------------------------------------------------------------
  // main sequence
  // ----------------------------------------------------------------------
  initial
  begin
    offs = '{`MTC_OFF_FIRST_COUNT, `MTC_OFF_CAPTURE_A, `MTC_OFF_CAPTURE_B,
             `MTC_OFF_SECOND_COUNT};
    csel2_on = 32'h00000001 << `MTC_CTL_CSEL2_LSB;
    repeat (8) @(posedge i_clk);
    i_resetn <= 1'b1;
    @(posedge i_clk);
    rdchk("divider", `MTC_OFF_DIVIDER, 32'h00000000);
    rdchk("control", `MTC_OFF_CONTROL, 32'h00000000);
    apb(1'b0, 8'h30, 32'h00000000);
    check("unmapped err", 32'h00000001, {31'h0, err});
    check("unmapped data", 32'h00000000, rd);
    $display("test reset and unmapped done");
    // enabled writes land, upper bits dropped; disabled writes ignored
    wr(`MTC_OFF_CONTROL, ctl(1'b1, 1'b0, 1'b0, 1'b0, 3'h0));
    for (int i = 0; i < 4; i++)
    begin
      vals[i] = 16'h1357 + 16'(i * 32'h1111);
      wr(offs[i], {16'hFFFF, vals[i]});
      rdchk("field enabled", offs[i], {16'h0, vals[i]});
    end
    // select off: the tick left over from disabling must step nothing
    wr(`MTC_OFF_CONTROL, ctl(1'b0, 1'b0, 1'b0, 1'b0, 3'h0));
    for (int i = 0; i < 4; i++)
    begin
      wr(offs[i], {16'h0, ~vals[i]});
      rdchk("field disabled", offs[i], {16'h0, vals[i]});
    end
    wr(`MTC_OFF_DIVIDER, 32'hFFFFFF03);
    rdchk("divider", `MTC_OFF_DIVIDER, 32'h00000003);
    $display("test register access done");
    // live count: first counter on prescaled clock, second stopped
    t0 = ticks;
    wr(`MTC_OFF_CONTROL, ctl(1'b1, 1'b0, 1'b0, 1'b0, 3'h1));
    repeat (40) @(posedge i_clk);
    wr(`MTC_OFF_CONTROL, ctl(1'b0, 1'b0, 1'b0, 1'b0, 3'h1));
    repeat (3) @(posedge i_clk);
    check("ticks seen", 32'h00000001, {31'h0, ticks > t0});
    rdchk("live count", offs[0], {16'h0, vals[0] - 16'(ticks - t0)});
    rdchk("stopped count", offs[3], {16'h0, vals[3]});
    // second counter on prescaled clock, select kept while disabling
    t0 = ticks;
    wr(`MTC_OFF_CONTROL, ctl(1'b1, 1'b0, 1'b0, 1'b0, 3'h0) | csel2_on);
    repeat (40) @(posedge i_clk);
    wr(`MTC_OFF_CONTROL, ctl(1'b0, 1'b0, 1'b0, 1'b0, 3'h0) | csel2_on);
    repeat (3) @(posedge i_clk);
    check("ticks seen 2", 32'h00000001, {31'h0, ticks > t0});
    rdchk("live count 2", offs[3], {16'h0, vals[3] - 16'(ticks - t0)});
    $display("test live count done");
    // tick period for each setting, rewritten while running
    wr(`MTC_OFF_CONTROL, ctl(1'b1, 1'b0, 1'b0, 1'b0, 3'h0));
    foreach (sets[i])
    begin
      wr(`MTC_OFF_DIVIDER, 32'(sets[i]));
      wait_tick(gap);
      wait_tick(gap);
      wait_tick(gap);
      check("tick period", 32'(sets[i] + 1), 32'(gap));
    end
    $display("test prescaler period done");
    // pulse train: new setting held until start, then until input b event
    wr(`MTC_OFF_CONTROL, ctl(1'b1, 1'b0, 1'b0, 1'b1, 3'h0));
    wr(`MTC_OFF_DIVIDER, 32'h00000002);
    wait_tick(gap);
    wait_tick(gap);
    check("train held", 32'h00000100, 32'(gap));
    wr(`MTC_OFF_CONTROL, ctl(1'b1, 1'b0, 1'b1, 1'b1, 3'h0));
    wait_tick(gap);
    check("start load", 32'h00000001, {31'h0, gap <= 8});
    wait_tick(gap);
    check("start period", 32'h00000003, 32'(gap));
    wr(`MTC_OFF_DIVIDER, 32'h000000FF);
    wr(`MTC_OFF_CONTROL, ctl(1'b1, 1'b1, 1'b0, 1'b1, 3'h0));
    i_timer_input_b <= 1'b1;
    repeat (10) @(posedge i_clk);
    wait_tick(gap);
    wait_tick(gap);
    check("trigger period", 32'h00000100, 32'(gap));
    i_timer_input_b <= 1'b0;
    $display("test pulse train done");
    tally_and_finish();
  end

endmodule // mtc_count_regs_tb_top

`default_nettype wire
